// *** design/isc_pkg.sv ***
// Shared constants and types for the idle-state coordinator
package isc_pkg;
   // -----------------------------------------------------------------
   // Ordered idle-state codes: deeper state, larger code
   // -----------------------------------------------------------------
   localparam logic [2:0] CS_C0 = 3'h0;
   localparam logic [2:0] CS_C1 = 3'h1;
   localparam logic [2:0] CS_C2 = 3'h2;
   localparam logic [2:0] CS_C3 = 3'h3;
   localparam logic [2:0] CS_C4 = 3'h4;
   localparam logic [2:0] CS_C6 = 3'h5;

   // -----------------------------------------------------------------
   // Idle-state configuration register fields
   // -----------------------------------------------------------------
   localparam int         CFG_W           = 8;
   localparam logic [7:0] CFG_RST         = 8'h00;
   localparam int         CFG_DEMOTE_C3   = 0;
   localparam int         CFG_DEMOTE_C1   = 1;
   localparam int         CFG_EXT_C1      = 2;

   // -----------------------------------------------------------------
   // Sequencing counts, in core_clk cycles
   // -----------------------------------------------------------------
   localparam logic [7:0]  FLUSH_CYCLES   = 8'h08;
   localparam logic [7:0]  SAVE_CYCLES    = 8'h08;
   localparam logic [7:0]  RESTORE_CYCLES = 8'h08;
   localparam logic [7:0]  VSTEP_CYCLES   = 8'h04;
   localparam logic [15:0] RES_THRESH_DEF = 16'h0100;

   typedef enum logic [2:0] {
      PW_RUN,
      PW_FLUSH,
      PW_GATED,
      PW_SAVE,
      PW_OFF,
      PW_RESTORE
   } isc_pwr_type;

   function automatic logic [2:0] isc_min(input logic [2:0] a, input logic [2:0] b);
      return (a < b) ? a : b;
   endfunction
endpackage

// *** design/isc_link_if.sv ***
// Link between the processor coordinator and the platform chipset logic
`timescale 1ns/1ps
interface isc_link_if;
   logic       stop_clock_request;
   logic       stop_grant_ack;
   logic [2:0] pkg_req;
   logic [2:0] pkg_grant;
   logic       break_valid;
   logic       break_core;
   logic       break_masked;
   logic       break_mem;
   logic       keep_high;

   modport device (
      input  stop_clock_request,
      output stop_grant_ack,
      output pkg_req,
      input  pkg_grant,
      input  break_valid,
      input  break_core,
      input  break_masked,
      input  break_mem,
      input  keep_high
   );

   modport platform (
      output stop_clock_request,
      input  stop_grant_ack,
      input  pkg_req,
      output pkg_grant,
      output break_valid,
      output break_core,
      output break_masked,
      output break_mem,
      output keep_high
   );
endinterface

// *** design/isc_device.sv ***
// Processor-side idle-state coordinator: threads, cores, package
`timescale 1ns/1ps
module isc_device #(
   parameter int          NC         = 2,
   parameter int          NT         = 2,
   parameter logic [15:0] RES_THRESH = isc_pkg::RES_THRESH_DEF
) (
   input  wire logic                   core_clk,
   input  wire logic                   resetn,
   isc_link_if.device                  lnk,
   input  wire logic                   sys_reset,
   input  wire logic [NC*NT-1:0]       req_valid,
   input  wire logic [NC*NT-1:0][2:0]  req_state,
   input  wire logic [NC*NT-1:0]       req_monitor_wait_request,
   input  wire logic [NC-1:0]          system_mgmt_interrupt,
   input  wire logic [NC-1:0]          init_request,
   input  wire logic [NC-1:0][1:0]     local_interrupt_lines,
   input  wire logic [NC-1:0]          bus_intr_msg,
   input  wire logic [NC-1:0]          monitor_event,
   input  wire logic [NC-1:0]          bus_snoop,
   input  wire logic [NC-1:0]          thread_snoop,
   input  wire logic                   cfg_wr,
   input  wire logic [7:0]             cfg_wdata,
   output logic [7:0]                  cfg_rdata,
   output logic [NC*NT-1:0][2:0]       thread_state,
   output logic [NC-1:0][2:0]          core_state,
   output logic [NC-1:0]               stop_granted,
   output logic [NC-1:0]               snoop_active,
   output logic [NC-1:0]               deeper_sleep_req,
   output logic [NC-1:0]               cache_flush,
   output logic [NC-1:0]               clocks_stopped,
   output logic [NC-1:0]               state_save,
   output logic [NC-1:0]               supply_off,
   output logic [NC-1:0]               state_restore,
   output logic [NC-1:0]               break_fwd,
   output logic [2:0]                  pkg_state,
   output logic                        freq_low,
   output logic                        volt_low
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0]                cfg_r,  cfg_nxt;
   logic [NC*NT-1:0][2:0]     ts_r,   ts_nxt;
   logic [NC*NT-1:0]          mw_r,   mw_nxt;
   logic [NC-1:0][2:0]        cs_r,   cs_nxt;
   logic [NC-1:0]             sg_r,   sg_nxt;
   logic [NC-1:0]             snp_r,  snp_nxt;
   logic [NC-1:0]             dsr_r,  dsr_nxt;
   logic [NC-1:0]             bfw_r,  bfw_nxt;
   logic [NC-1:0]             rok_r,  rok_nxt;
   logic [NC-1:0][15:0]       res_r,  res_nxt;
   logic [NC-1:0][7:0]        pc_r,   pc_nxt;
   isc_pkg::isc_pwr_type      pw_r [NC], pw_nxt [NC];
   logic [2:0]                preq_r, preq_nxt;
   logic [2:0]                pk_r,   pk_nxt;
   logic                      hold_r, hold_nxt;
   logic                      ack_r,  ack_nxt;
   logic                      fl_r,   fl_nxt;
   logic                      vl_r,   vl_nxt;
   logic [7:0]                vc_r,   vc_nxt;
   logic [NC-1:0]             brk;
   logic [NC-1:0]             halt_brk;
   logic [NC-1:0][2:0]        raw;

   // ----------------------------------------------------------------
   // Thread and core resolution
   // ----------------------------------------------------------------
   always_comb begin
      cfg_nxt  = cfg_wr ? cfg_wdata : cfg_r;
      ts_nxt   = ts_r;
      mw_nxt   = mw_r;
      cs_nxt   = cs_r;
      sg_nxt   = sg_r;
      snp_nxt  = '0;
      dsr_nxt  = '0;
      bfw_nxt  = '0;
      rok_nxt  = rok_r;
      res_nxt  = res_r;
      pc_nxt   = pc_r;
      brk      = '0;
      halt_brk = '0;
      raw      = '0;
      ack_nxt  = 1'b0;
      for (int c = 0; c < NC; c++) begin
         pw_nxt[c]   = pw_r[c];
         brk[c]      = lnk.break_valid && (lnk.break_core == 1'(c));
         bfw_nxt[c]  = brk[c];
         halt_brk[c] = system_mgmt_interrupt[c] | init_request[c] | (|local_interrupt_lines[c]) | bus_intr_msg[c];
         for (int t = 0; t < NT; t++) begin
            if (sys_reset) begin
               ts_nxt[c*NT+t] = isc_pkg::CS_C0;
            end else if (brk[c] && !lnk.break_masked && !lnk.break_mem) begin
               ts_nxt[c*NT+t] = isc_pkg::CS_C0;
            end else if (halt_brk[c] && !lnk.stop_clock_request && ts_r[c*NT+t] != isc_pkg::CS_C0) begin
               ts_nxt[c*NT+t] = isc_pkg::CS_C0;
            end else if (monitor_event[c] && mw_r[c*NT+t] && !lnk.stop_clock_request) begin
               ts_nxt[c*NT+t] = isc_pkg::CS_C0;
            end else if (req_valid[c*NT+t] && ts_r[c*NT+t] == isc_pkg::CS_C0) begin
               ts_nxt[c*NT+t] = req_state[c*NT+t];
               mw_nxt[c*NT+t] = req_monitor_wait_request[c*NT+t];
            end
         end
         // Core takes the shallowest thread state
         raw[c] = ts_nxt[c*NT];
         for (int t = 1; t < NT; t++) begin
            raw[c] = isc_pkg::isc_min(raw[c], ts_nxt[c*NT+t]);
         end
         cs_nxt[c]  = raw[c];
         dsr_nxt[c] = (raw[c] == isc_pkg::CS_C4);
         // Demote C6 until the last deep residency was long enough
         if (raw[c] == isc_pkg::CS_C6 && !rok_r[c]) begin
            if (cfg_r[isc_pkg::CFG_DEMOTE_C3]) begin
               cs_nxt[c] = isc_pkg::CS_C3;
            end else if (cfg_r[isc_pkg::CFG_DEMOTE_C1]) begin
               cs_nxt[c] = isc_pkg::CS_C1;
            end
         end
         if (cs_r[c] >= isc_pkg::CS_C3 && cs_nxt[c] < isc_pkg::CS_C3) begin
            rok_nxt[c] = (res_r[c] >= RES_THRESH);
            res_nxt[c] = '0;
         end else if (cs_r[c] >= isc_pkg::CS_C3 && res_r[c] != 16'hFFFF) begin
            res_nxt[c] = res_r[c] + 16'h0001;
         end
         // Stop-grant is a sub-state: release lands back in C1/C2, not C0
         sg_nxt[c] = lnk.stop_clock_request &&
                     (cs_nxt[c] == isc_pkg::CS_C1 || cs_nxt[c] == isc_pkg::CS_C2);
         if (sg_nxt[c] && !sg_r[c]) begin
            ack_nxt = 1'b1;
         end
         // Snoops only touch shallow states; deep cores stay asleep
         snp_nxt[c] = (bus_snoop[c] | thread_snoop[c]) &&
                      (cs_r[c] == isc_pkg::CS_C1 || cs_r[c] == isc_pkg::CS_C2);
         // Power sequencing for C4 and C6
         case (pw_r[c])
            isc_pkg::PW_RUN: begin
               pc_nxt[c] = '0;
               if (cs_nxt[c] == isc_pkg::CS_C6) begin
                  pw_nxt[c] = isc_pkg::PW_SAVE;
               end else if (cs_nxt[c] == isc_pkg::CS_C4) begin
                  pw_nxt[c] = isc_pkg::PW_FLUSH;
               end
            end
            isc_pkg::PW_FLUSH: begin
               pc_nxt[c] = pc_r[c] + 8'h01;
               if (pc_r[c] == isc_pkg::FLUSH_CYCLES - 8'h01) begin
                  pw_nxt[c] = isc_pkg::PW_GATED;
               end
            end
            isc_pkg::PW_GATED: begin
               pc_nxt[c] = '0;
               if (cs_nxt[c] == isc_pkg::CS_C6) begin
                  pw_nxt[c] = isc_pkg::PW_SAVE;
               end else if (cs_nxt[c] < isc_pkg::CS_C4) begin
                  pw_nxt[c] = isc_pkg::PW_RUN;
               end
            end
            isc_pkg::PW_SAVE: begin
               pc_nxt[c] = pc_r[c] + 8'h01;
               if (pc_r[c] == isc_pkg::SAVE_CYCLES - 8'h01) begin
                  pw_nxt[c] = isc_pkg::PW_OFF;
               end
            end
            isc_pkg::PW_OFF: begin
               pc_nxt[c] = '0;
               if (cs_nxt[c] < isc_pkg::CS_C6) begin
                  pw_nxt[c] = isc_pkg::PW_RESTORE;
               end
            end
            isc_pkg::PW_RESTORE: begin
               pc_nxt[c] = pc_r[c] + 8'h01;
               if (pc_r[c] == isc_pkg::RESTORE_CYCLES - 8'h01) begin
                  pw_nxt[c] = isc_pkg::PW_RUN;
               end
            end
            default: begin
               pw_nxt[c] = isc_pkg::PW_RUN;
               pc_nxt[c] = '0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Package resolution and extended C1
   // ----------------------------------------------------------------
   always_comb begin
      preq_nxt = cs_nxt[0];
      for (int c = 1; c < NC; c++) begin
         preq_nxt = isc_pkg::isc_min(preq_nxt, cs_nxt[c]);
      end
      // Memory break held high while the platform asks for it
      hold_nxt = (lnk.break_valid && lnk.break_mem && lnk.keep_high) ||
                 (hold_r && lnk.keep_high);
      // Cores keep their own deeper states; only the package is capped
      pk_nxt = isc_pkg::isc_min(preq_r, lnk.pkg_grant);
      if (hold_nxt || lnk.break_valid) begin
         pk_nxt = isc_pkg::CS_C0;
      end
      fl_nxt = 1'b0;
      vl_nxt = 1'b0;
      vc_nxt = '0;
      if (cfg_r[isc_pkg::CFG_EXT_C1] && pk_r == isc_pkg::CS_C1 && pk_nxt == isc_pkg::CS_C1) begin
         fl_nxt = 1'b1;
         vc_nxt = vc_r;
         vl_nxt = vl_r;
         if (fl_r && vc_r != isc_pkg::VSTEP_CYCLES - 8'h01) begin
            vc_nxt = vc_r + 8'h01;
         end else if (fl_r) begin
            vl_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_r  <= isc_pkg::CFG_RST;
         ts_r   <= '0;
         mw_r   <= '0;
         cs_r   <= '0;
         sg_r   <= '0;
         snp_r  <= '0;
         dsr_r  <= '0;
         bfw_r  <= '0;
         rok_r  <= '0;
         res_r  <= '0;
         pc_r   <= '0;
         for (int c = 0; c < NC; c++) begin
            pw_r[c] <= isc_pkg::PW_RUN;
         end
         preq_r <= isc_pkg::CS_C0;
         pk_r   <= isc_pkg::CS_C0;
         hold_r <= 1'b0;
         ack_r  <= 1'b0;
         fl_r   <= 1'b0;
         vl_r   <= 1'b0;
         vc_r   <= '0;
      end else begin
         cfg_r  <= cfg_nxt;
         ts_r   <= ts_nxt;
         mw_r   <= mw_nxt;
         cs_r   <= cs_nxt;
         sg_r   <= sg_nxt;
         snp_r  <= snp_nxt;
         dsr_r  <= dsr_nxt;
         bfw_r  <= bfw_nxt;
         rok_r  <= rok_nxt;
         res_r  <= res_nxt;
         pc_r   <= pc_nxt;
         pw_r   <= pw_nxt;
         preq_r <= preq_nxt;
         pk_r   <= pk_nxt;
         hold_r <= hold_nxt;
         ack_r  <= ack_nxt;
         fl_r   <= fl_nxt;
         vl_r   <= vl_nxt;
         vc_r   <= vc_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   generate
      for (genvar g = 0; g < NC; g++) begin : g_core
         assign cache_flush[g]    = (pw_r[g] == isc_pkg::PW_FLUSH);
         assign clocks_stopped[g] = (pw_r[g] == isc_pkg::PW_GATED);
         assign state_save[g]     = (pw_r[g] == isc_pkg::PW_SAVE);
         assign supply_off[g]     = (pw_r[g] == isc_pkg::PW_OFF);
         assign state_restore[g]  = (pw_r[g] == isc_pkg::PW_RESTORE);
      end
   endgenerate

   assign cfg_rdata          = cfg_r;
   assign thread_state       = ts_r;
   assign core_state         = cs_r;
   assign stop_granted       = sg_r;
   assign snoop_active       = snp_r;
   assign deeper_sleep_req   = dsr_r;
   assign break_fwd          = bfw_r;
   assign pkg_state          = pk_r;
   assign freq_low           = fl_r;
   assign volt_low           = vl_r;
   assign lnk.stop_grant_ack = ack_r;
   assign lnk.pkg_req        = preq_r;
endmodule // isc_device

// *** design/isc_platform.sv ***
// Platform-side end: stop-clock, package grants and break events
`timescale 1ns/1ps
module isc_platform (
   input  wire logic       core_clk,
   input  wire logic       resetn,
   isc_link_if.platform    lnk,
   input  wire logic       stop_req,
   input  wire logic [2:0] grant_limit,
   input  wire logic       brk_pulse,
   input  wire logic       brk_core,
   input  wire logic       brk_masked,
   input  wire logic       brk_mem,
   input  wire logic       keep_high_req,
   output logic [2:0]      pkg_req_seen,
   output logic            stop_acked
);
   logic       stp_r, stp_nxt;
   logic [2:0] gnt_r, gnt_nxt;
   logic       bv_r,  bv_nxt;
   logic       bc_r,  bc_nxt;
   logic       bm_r,  bm_nxt;
   logic       bme_r, bme_nxt;
   logic       kh_r,  kh_nxt;
   logic [2:0] seen_r, seen_nxt;
   logic       ack_r, ack_nxt;

   // ----------------------------------------------------------------
   // Link drive
   // ----------------------------------------------------------------
   always_comb begin
      stp_nxt  = stop_req;
      // Grant no deeper than the limit the platform allows
      gnt_nxt  = isc_pkg::isc_min(lnk.pkg_req, grant_limit);
      bv_nxt   = brk_pulse;
      bc_nxt   = brk_core;
      bm_nxt   = brk_masked;
      bme_nxt  = brk_mem;
      kh_nxt   = keep_high_req;
      seen_nxt = lnk.pkg_req;
      // Set wins over the clear on the same cycle
      ack_nxt  = lnk.stop_grant_ack || (ack_r && stop_req);
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stp_r  <= 1'b0;
         gnt_r  <= isc_pkg::CS_C0;
         bv_r   <= 1'b0;
         bc_r   <= 1'b0;
         bm_r   <= 1'b0;
         bme_r  <= 1'b0;
         kh_r   <= 1'b0;
         seen_r <= isc_pkg::CS_C0;
         ack_r  <= 1'b0;
      end else begin
         stp_r  <= stp_nxt;
         gnt_r  <= gnt_nxt;
         bv_r   <= bv_nxt;
         bc_r   <= bc_nxt;
         bm_r   <= bm_nxt;
         bme_r  <= bme_nxt;
         kh_r   <= kh_nxt;
         seen_r <= seen_nxt;
         ack_r  <= ack_nxt;
      end
   end

   assign lnk.stop_clock_request = stp_r;
   assign lnk.pkg_grant          = gnt_r;
   assign lnk.break_valid        = bv_r;
   assign lnk.break_core         = bc_r;
   assign lnk.break_masked       = bm_r;
   assign lnk.break_mem          = bme_r;
   assign lnk.keep_high          = kh_r;
   assign pkg_req_seen           = seen_r;
   assign stop_acked             = ack_r;
endmodule // isc_platform

// *** sim/isc_link_checker.sv ***
// Checker of the link between the coordinator and the platform end
`timescale 1ns/1ps
module isc_link_checker (
   input wire logic       core_clk,
   input wire logic       resetn,
   input wire logic       stop_clock_request,
   input wire logic       stop_grant_ack,
   input wire logic [2:0] pkg_req,
   input wire logic [2:0] pkg_grant,
   input wire logic       break_valid,
   input wire logic       break_core,
   input wire logic       break_masked,
   input wire logic       break_mem,
   input wire logic       keep_high
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // ------------------------------------------------------------
   // Link properties
   // ------------------------------------------------------------
   req_code_a:
      assert property (pkg_req <= isc_pkg::CS_C6) else $error("package request code out of range");
   grant_code_a:
      assert property (pkg_grant <= isc_pkg::CS_C6) else $error("package grant code out of range");
   grant_depth_a:
      assert property (pkg_grant <= $past(pkg_req)) else $error("grant deeper than request");
   ack_cause_a:
      assert property (stop_grant_ack |-> $past(stop_clock_request)) else $error("ack without stop clock");
   ack_pulse_a:
      assert property (stop_grant_ack |=> !stop_grant_ack) else $error("ack longer than one cycle");
   ack_quiet_a:
      assert property (!stop_clock_request [*2] |-> !stop_grant_ack) else $error("ack while stop clock low");
   brk_once_a:
      assert property (break_valid |=> !break_valid) else $error("break event longer than one cycle");
   // Unmasked core break must pull the whole package request back to run
   wake_pkg_a:
      assert property (break_valid && !break_masked && !break_mem |-> ##[1:3] pkg_req == isc_pkg::CS_C0)
         else $error("unmasked break left package request idle");
endmodule // isc_link_checker

// *** sim/idle_state_coordinator_test.sv ***
// Self-checking bench: coordinator and platform end joined by the link
`timescale 1ns/1ps
module idle_state_coordinator_test;
   logic            core_clk = 1'b0;
   logic            resetn = 1'b0;
   logic            sys_reset = 1'b0;
   logic [3:0]      req_valid = 4'h0;
   logic [3:0][2:0] req_state = 12'h000;
   logic [3:0]      req_monitor_wait_request = 4'h0;
   logic [1:0]      system_mgmt_interrupt = 2'h0;
   logic [1:0]      init_request = 2'h0;
   logic [1:0][1:0] local_interrupt_lines = 4'h0;
   logic [1:0]      bus_intr_msg = 2'h0;
   logic [1:0]      monitor_event = 2'h0;
   logic [1:0]      bus_snoop = 2'h0;
   logic [1:0]      thread_snoop = 2'h0;
   logic            cfg_wr = 1'b0;
   logic [7:0]      cfg_wdata = 8'h00;
   logic [7:0]      cfg_rdata;
   logic [3:0][2:0] thread_state;
   logic [1:0][2:0] core_state;
   logic [1:0]      stop_granted, snoop_active, deeper_sleep_req, cache_flush, clocks_stopped, supply_off, break_fwd;
   logic [2:0]      pkg_state;
   logic [1:0]      state_save;
   logic            freq_low, volt_low;
   logic [2:0]      pkg_req_seen;
   logic            stop_req = 1'b0, brk_pulse = 1'b0, brk_core = 1'b0, brk_masked = 1'b0, brk_mem = 1'b0;
   logic            keep_high_req = 1'b0;
   logic            stop_acked;
   logic [2:0]      grant_limit = isc_pkg::CS_C6;
   int              num_errors = 0;
   int              check_count = 0;

   isc_link_if link_bus ();
   // Short residency threshold keeps the demotion history test brief
   isc_device #(.RES_THRESH(16'h0004)) i_isc_device (.core_clk, .resetn, .lnk(link_bus), .sys_reset, .req_valid,
      .req_state, .req_monitor_wait_request, .system_mgmt_interrupt, .init_request, .local_interrupt_lines, .bus_intr_msg,
      .monitor_event, .bus_snoop, .thread_snoop, .cfg_wr, .cfg_wdata, .cfg_rdata, .thread_state, .core_state,
      .stop_granted, .snoop_active, .deeper_sleep_req, .cache_flush, .clocks_stopped, .state_save,
      .supply_off, .state_restore(), .break_fwd, .pkg_state, .freq_low, .volt_low);
   isc_platform i_isc_platform (.core_clk, .resetn, .lnk(link_bus), .stop_req, .grant_limit, .brk_pulse,
      .brk_core, .brk_masked, .brk_mem, .keep_high_req, .pkg_req_seen, .stop_acked);
   isc_link_checker i_chk (.core_clk, .resetn, .stop_clock_request(link_bus.stop_clock_request),
      .stop_grant_ack(link_bus.stop_grant_ack), .pkg_req(link_bus.pkg_req), .pkg_grant(link_bus.pkg_grant),
      .break_valid(link_bus.break_valid), .break_core(link_bus.break_core),
      .break_masked(link_bus.break_masked), .break_mem(link_bus.break_mem), .keep_high(link_bus.keep_high));

   always #2 core_clk = ~core_clk;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk_st(input logic [2:0] got, input logic [2:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask
   task automatic req(input logic [3:0] m, input logic [2:0] st);
      for (int i = 0; i < 4; i++) req_state[i] = st;
      req_valid = m;
      step(1);
      req_valid = 4'h0;
   endtask
   task automatic wake_set(input int k, input logic v);
      case (k)
         0: system_mgmt_interrupt[0] = v;
         1: init_request[0] = v;
         2: local_interrupt_lines[0][0] = v;
         3: local_interrupt_lines[0][1] = v;
         default: bus_intr_msg[0] = v;
      endcase
   endtask
   task automatic wake1();
      system_mgmt_interrupt[1] = 1'b1;
      step(1);
      system_mgmt_interrupt[1] = 1'b0;
   endtask
   task automatic cfg_put(input logic [7:0] v);
      cfg_wdata = v;
      cfg_wr = 1'b1;
      step(1);
      cfg_wr = 1'b0;
   endtask
   task automatic brk_ev(input logic m, input logic e);
      brk_masked = m;
      brk_mem = e;
      brk_pulse = 1'b1;
      step(1);
      brk_pulse = 1'b0;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_halt();
      req(4'h1, isc_pkg::CS_C1);
      chk_st(core_state[0], isc_pkg::CS_C0, "one idle thread moved core");
      step(1);
      req(4'h2, isc_pkg::CS_C1);
      chk_st(thread_state[1], isc_pkg::CS_C1, "second thread not halted");
      for (int k = 0; k < 5; k++) begin
         if (k > 0) req(4'h3, isc_pkg::CS_C1);
         chk_st(core_state[0], isc_pkg::CS_C1, "core not C1");
         wake_set(k, 1'b1);
         step(1);
         wake_set(k, 1'b0);
         step(1);
         chk_st(core_state[0], isc_pkg::CS_C0, "interrupt did not wake");
      end
      req_monitor_wait_request = 4'h3;
      req(4'h3, isc_pkg::CS_C1);
      req_monitor_wait_request = 4'h0;
      monitor_event[0] = 1'b1;
      step(1);
      monitor_event[0] = 1'b0;
      step(1);
      chk_st(core_state[0], isc_pkg::CS_C0, "monitor event did not wake");
      $display("t_halt done");
   endtask

   task automatic t_stop();
      logic seen;
      req(4'h3, isc_pkg::CS_C2);
      chk_st(core_state[0], isc_pkg::CS_C2, "core not C2");
      step(2);
      chk_bit(stop_acked, 1'b0, "ack without stop clock");
      stop_req = 1'b1;
      step(3);
      chk_bit(stop_granted[0], 1'b1, "no stop grant");
      chk_bit(stop_acked, 1'b1, "no ack");
      wake_set(0, 1'b1);
      step(1);
      wake_set(0, 1'b0);
      step(1);
      chk_st(core_state[0], isc_pkg::CS_C2, "woken under stop clock");
      stop_req = 1'b0;
      step(3);
      chk_bit(stop_granted[0], 1'b0, "grant held after release");
      chk_st(core_state[0], isc_pkg::CS_C2, "release left halted state");
      thread_snoop[0] = 1'b1;
      step(1);
      seen = snoop_active[0];
      thread_snoop[0] = 1'b0;
      step(1);
      seen = seen | snoop_active[0];
      chk_bit(seen, 1'b1, "snoop not served");
      chk_st(core_state[0], isc_pkg::CS_C2, "snoop changed state");
      wake_set(2, 1'b1);
      step(1);
      wake_set(2, 1'b0);
      step(1);
      chk_st(core_state[0], isc_pkg::CS_C0, "no wake after stop");
      $display("t_stop done");
   endtask

   task automatic t_deep();
      req(4'h3, isc_pkg::CS_C4);
      step(1);
      chk_bit(cache_flush[0], 1'b1, "no flush");
      step(8);
      chk_bit(clocks_stopped[0], 1'b1, "clocks running");
      chk_bit(deeper_sleep_req[0], 1'b1, "no deeper sleep request");
      bus_snoop[0] = 1'b1;
      step(2);
      bus_snoop[0] = 1'b0;
      chk_bit(snoop_active[0], 1'b0, "snoop served in C4");
      chk_st(core_state[0], isc_pkg::CS_C4, "snoop woke C4");
      sys_reset = 1'b1;
      step(1);
      sys_reset = 1'b0;
      step(1);
      chk_st(thread_state[0], isc_pkg::CS_C0, "reset did not wake");
      $display("t_deep done");
   endtask

   task automatic t_demote();
      logic [7:0] cv [2] = '{8'h01, 8'h02};
      logic [2:0] ev [2] = '{isc_pkg::CS_C3, isc_pkg::CS_C1};
      chk_bit(cfg_rdata == 8'h00, 1'b1, "config not clear after reset");
      req(4'hC, isc_pkg::CS_C6);
      chk_st(core_state[1], isc_pkg::CS_C6, "demoted while disabled");
      wake1();
      for (int k = 0; k < 2; k++) begin
         cfg_put(cv[k]);
         step(1);
         chk_bit(cfg_rdata == cv[k], 1'b1, "config readback");
         req(4'hC, isc_pkg::CS_C6);
         chk_st(core_state[1], ev[k], "C6 not demoted");
         wake1();
         step(1);
      end
      // Long deep stay earns a real C6 next time
      req(4'hC, isc_pkg::CS_C4);
      step(4);
      wake1();
      req(4'hC, isc_pkg::CS_C6);
      chk_st(core_state[1], isc_pkg::CS_C6, "demoted after long residency");
      wake1();
      cfg_put(8'h00);
      $display("t_demote done");
   endtask

   task automatic t_pkg();
      logic seen = 1'b0;
      grant_limit = isc_pkg::CS_C2;
      req(4'hF, isc_pkg::CS_C6);
      chk_bit(state_save[0], 1'b1, "no state save");
      step(24);
      chk_bit(supply_off[1], 1'b1, "C6 supply not off");
      chk_st(pkg_req_seen, isc_pkg::CS_C6, "package request");
      chk_st(pkg_state, isc_pkg::CS_C2, "package beyond grant");
      brk_core = 1'b1;
      keep_high_req = 1'b1;
      brk_ev(1'b0, 1'b1);
      step(3);
      chk_st(pkg_state, isc_pkg::CS_C0, "memory break let package sleep");
      chk_st(core_state[1], isc_pkg::CS_C6, "memory break woke core");
      keep_high_req = 1'b0;
      step(3);
      chk_st(pkg_state, isc_pkg::CS_C2, "package not back after hold");
      brk_ev(1'b1, 1'b0);
      step(2);
      chk_st(pkg_state, isc_pkg::CS_C2, "masked break left package");
      chk_st(core_state[1], isc_pkg::CS_C6, "masked break woke core");
      brk_ev(1'b0, 1'b0);
      repeat (4) begin
         step(1);
         seen = seen | break_fwd[1];
      end
      chk_bit(seen, 1'b1, "break not forwarded");
      chk_st(core_state[1], isc_pkg::CS_C0, "target core idle");
      step(4);
      chk_st(pkg_state, isc_pkg::CS_C0, "package not running");
      cfg_put(8'h04);
      req(4'hC, isc_pkg::CS_C1);
      step(4);
      chk_bit(freq_low, 1'b1, "clock not lowered in C1");
      chk_bit(volt_low, 1'b0, "voltage before clock");
      step(4);
      chk_bit(volt_low, 1'b1, "voltage not lowered");
      $display("t_pkg done");
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #20000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      step(4);
      resetn = 1'b1;
      t_halt();
      t_stop();
      t_deep();
      t_demote();
      t_pkg();
      report_and_stop();
   end
endmodule // idle_state_coordinator_test
